// >>> sacs_pkg.sv
`default_nettype none
package sacs_pkg;
    // Serial frame shape
    localparam int CTRL_BITS = 8;
    localparam int READ_BITS = 16;
    localparam int CODE_BITS = 12;
    localparam int TRAIL_ZEROS = 3;
    localparam int NUM_CH = 8;
    // Control byte fields
    localparam int CB_START = 7;
    localparam int CB_SEL_LSB = 4;
    localparam int CB_UNI = 3;
    localparam int CB_SGL = 2;
    localparam int CB_PD_LSB = 0;
    // Power bits of the control byte
    typedef enum logic [1:0] {
        PD_DEEP = 2'b00,
        PD_QUICK = 2'b01,
        PD_INTCLK = 2'b10,
        PD_EXTCLK = 2'b11
    } sacs_pd_t;
    // Device power state
    typedef enum logic [1:0] {
        PWR_AWAKE = 2'b00,
        PWR_QUICK = 2'b01,
        PWR_DEEP = 2'b10
    } sacs_power_t;
    // Settling sequence before a scan
    typedef enum logic [1:0] {
        SETTLE_NONE = 2'b00,
        SETTLE_EXT = 2'b01,
        SETTLE_INT = 2'b10
    } sacs_settle_t;
    // Timing
    localparam int CLOCK_NS = 8;
    localparam int CLOCK_KHZ = 125000;
    localparam int SCLK_PERIOD_NS = 64;
    localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * CLOCK_NS);
    localparam int IDLE_CLOCKS = 75;
    localparam int SETTLE_TIME_MS = 2;
    localparam int SETTLE_CYCLES = SETTLE_TIME_MS * CLOCK_KHZ;
    // Register map of the host controller
    localparam int ADR_BITS = 8;
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RESULT = 8'h20;
    localparam int CTL_GO = 0;
    localparam int CTL_LAST_LSB = 1;
    localparam int CTL_SETTLE_LSB = 4;
    localparam int STS_BUSY = 0;
    localparam int STS_DONE = 1;
    localparam int STS_STROBE_ERR = 2;
    // Reset values
    localparam logic [2:0] LAST_CH_RESET = 3'h7;
    localparam logic STROBE_RESET = 1'b1;
endpackage
`default_nettype wire

// >>> sacs_link.sv
`timescale 1ns/1ps
`default_nettype none
interface sacs_link;
    logic sclk;
    logic chipSelectN;
    logic dataToDev;
    logic dataFromDev;
    logic conversionStrobe;
    modport device (
        input sclk,
        input chipSelectN,
        input dataToDev,
        output dataFromDev,
        output conversionStrobe
    );
    modport host (
        output sclk,
        output chipSelectN,
        output dataToDev,
        input dataFromDev,
        input conversionStrobe
    );
endinterface
`default_nettype wire

// >>> sacs_device.sv
`timescale 1ns/1ps
`default_nettype none
module sacs_device
(
    // Link to host
    sacs_link.device link,
    // Reset and freeze, link clock domain
    input wire logic rst_n,
    input wire logic ce,
    // Converter core
    input wire logic [sacs_pkg::CODE_BITS-1:0] sampleCode,
    output logic convStart,
    output logic [2:0] channelSel,
    output logic unipolar,
    output logic singleEnded,
    output sacs_pkg::sacs_power_t powerState,
    output logic extClockMode
);
    typedef struct packed {
        logic [3:0] rxCnt;
        logic [6:0] rxByte;
        logic [4:0] outCnt;
        logic [15:0] outShift;
        logic [1:0] pendPd;
        logic convStart;
        logic [2:0] chan;
        logic uni;
        logic sgl;
        sacs_pkg::sacs_power_t power;
        logic extClk;
    } sacs_dev_t;

    typedef struct packed {
        logic dout;
        logic strobe;
    } sacs_edge_t;

    sacs_dev_t s_r;
    sacs_dev_t s_nxt;
    sacs_edge_t e_r;
    sacs_edge_t e_nxt;
    logic [7:0] ctrlByte;

    // Control byte as it completes on this edge
    assign ctrlByte = {s_r.rxByte, link.dataToDev};

    // Receive control bytes, run readout, track power
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.convStart = 1'b0;
        if (link.chipSelectN)
        begin
            s_nxt.rxCnt = 4'h0;
            s_nxt.outCnt = 5'h00;
        end
        else
        begin
            if (s_r.outCnt != 5'h00)
            begin
                s_nxt.outShift = {s_r.outShift[14:0], 1'b0};
                s_nxt.outCnt = s_r.outCnt - 5'h01;
                if (s_r.outCnt == 5'h01 && !s_r.pendPd[1])
                begin
                    s_nxt.power = s_r.pendPd[0] ? sacs_pkg::PWR_QUICK
                        : sacs_pkg::PWR_DEEP;
                end
            end
            if (s_r.rxCnt == 4'h0)
            begin
                if (link.dataToDev)
                begin
                    s_nxt.rxCnt = 4'h1;
                    s_nxt.rxByte = 7'h01;
                    s_nxt.power = sacs_pkg::PWR_AWAKE;
                end
            end
            else if (s_r.rxCnt == 4'(sacs_pkg::CTRL_BITS - 1))
            begin
                s_nxt.rxCnt = 4'h0;
                s_nxt.chan = ctrlByte[sacs_pkg::CB_SEL_LSB +: 3];
                s_nxt.uni = ctrlByte[sacs_pkg::CB_UNI];
                s_nxt.sgl = ctrlByte[sacs_pkg::CB_SGL];
                s_nxt.pendPd = ctrlByte[sacs_pkg::CB_PD_LSB +: 2];
                if (ctrlByte[sacs_pkg::CB_PD_LSB + 1])
                begin
                    s_nxt.extClk = ctrlByte[sacs_pkg::CB_PD_LSB];
                end
                s_nxt.power = sacs_pkg::PWR_AWAKE;
                s_nxt.convStart = 1'b1;
                // Lead zero, straight binary code, zero tail
                s_nxt.outShift = {1'b0, sampleCode,
                    {sacs_pkg::TRAIL_ZEROS{1'b0}}};
                s_nxt.outCnt = 5'(sacs_pkg::READ_BITS);
            end
            else
            begin
                s_nxt.rxByte = {s_r.rxByte[5:0], link.dataToDev};
                s_nxt.rxCnt = s_r.rxCnt + 4'h1;
            end
        end
    end

    // Rising edge state
    always_ff @(posedge link.sclk)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
            s_r.power <= sacs_pkg::PWR_AWAKE;
        end
        else if (ce)
        begin
            s_r <= s_nxt;
        end
    end

    // Output pins change on the falling edge
    always_comb
    begin
        e_nxt.dout = s_r.outShift[15] & (s_r.outCnt != 5'h00);
        e_nxt.strobe = (s_r.outCnt == 5'h00);
    end

    always_ff @(negedge link.sclk)
    begin
        if (!rst_n)
        begin
            e_r.dout <= 1'b0;
            e_r.strobe <= sacs_pkg::STROBE_RESET;
        end
        else if (ce)
        begin
            e_r <= e_nxt;
        end
    end

    // Pins and core outputs
    assign link.dataFromDev = e_r.dout;
    assign link.conversionStrobe = e_r.strobe;
    assign convStart = s_r.convStart;
    assign channelSel = s_r.chan;
    assign unipolar = s_r.uni;
    assign singleEnded = s_r.sgl;
    assign powerState = s_r.power;
    assign extClockMode = s_r.extClk;
endmodule // sacs_device
`default_nettype wire

// >>> sacs_host.sv
// Chosen here: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
module sacs_host
#(
    parameter int SCLK_HALF = sacs_pkg::SCLK_HALF_CYCLES,
    parameter int SETTLE_CYCLES = sacs_pkg::SETTLE_CYCLES
)
(
    // Clock, reset, freeze
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [sacs_pkg::ADR_BITS-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Link to converter
    sacs_link.host link
);
    localparam int IDLE_WAIT = sacs_pkg::IDLE_CLOCKS * 2 * SCLK_HALF;

    // Half period must leave room for the two-stage synchroniser
    if (SCLK_HALF < 3 || SCLK_HALF > 255 || SETTLE_CYCLES < 1)
    begin : g_bad_param
        $error("SCLK_HALF or SETTLE_CYCLES out of range");
    end

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_SHIFT = 2'b01,
        H_WAIT = 2'b10
    } sacs_hstate_t;

    typedef struct packed {
        sacs_hstate_t state;
        logic scan;
        logic ack;
        logic [31:0] rdat;
        logic [2:0] lastCh;
        logic [1:0] settle;
        logic done;
        logic strobeErr;
        logic [7:0][15:0] res;
        logic [7:0] halfCnt;
        logic sclk;
        logic csN;
        logic din;
        logic [7:0] bits;
        logic [15:0] rx;
        logic [31:0] waitCnt;
        logic doutMeta;
        logic doutSync;
        logic strMeta;
        logic strSync;
    } sacs_host_t;

    sacs_host_t s_r;
    sacs_host_t s_nxt;
    logic tick;
    logic rise;
    logic fall;
    logic [7:0] total;
    logic [4:0] byteIdx;
    logic isCtrl;
    logic [1:0] pdBits;
    logic [7:0] ctrlByte;
    logic txBit;
    logic [7:0] bitsInc;
    logic [15:0] rxInc;
    logic [7:0] wordNum;
    logic wbReq;
    logic [31:0] readMux;

    // Clock divider events
    assign tick = (s_r.halfCnt == 8'(SCLK_HALF - 1));
    assign rise = tick & !s_r.sclk;
    assign fall = tick & s_r.sclk;

    // Frame length: dummy is one byte plus one readout
    assign total = s_r.scan
        ? 8'(sacs_pkg::CTRL_BITS + sacs_pkg::READ_BITS
            * (int'(s_r.lastCh) + 1))
        : 8'(sacs_pkg::CTRL_BITS + sacs_pkg::READ_BITS);

    // Even bytes up to channel lastCh carry control for channel byteIdx/2 (byte 0 only in the dummy), rest are zero
    assign byteIdx = s_r.bits[7:3];
    assign isCtrl = !byteIdx[0] && (s_r.scan
        ? ({1'b0, byteIdx[4:1]} <= {2'b00, s_r.lastCh})
        : (byteIdx == 5'h00));
    assign pdBits = (!s_r.scan && s_r.settle == sacs_pkg::SETTLE_INT)
        ? sacs_pkg::PD_QUICK : sacs_pkg::PD_EXTCLK;
    assign ctrlByte = {1'b1, byteIdx[3:1], 1'b1, 1'b1, pdBits};
    assign txBit = isCtrl & ctrlByte[3'h7 - s_r.bits[2:0]];

    // Next bit count and receive word on a rising edge
    assign bitsInc = s_r.bits + 8'h01;
    assign rxInc = {s_r.rx[14:0], s_r.doutSync};
    assign wordNum = (bitsInc - 8'(sacs_pkg::CTRL_BITS)) >> 4;

    // Register read mux
    assign wbReq = cyc_i & stb_i;
    always_comb
    begin
        readMux = 32'h0000_0000;
        if (adr_i == sacs_pkg::REG_CONTROL)
        begin
            readMux[sacs_pkg::CTL_LAST_LSB +: 3] = s_r.lastCh;
            readMux[sacs_pkg::CTL_SETTLE_LSB +: 2] = s_r.settle;
        end
        else if (adr_i == sacs_pkg::REG_STATUS)
        begin
            readMux[sacs_pkg::STS_BUSY] = (s_r.state != H_IDLE);
            readMux[sacs_pkg::STS_DONE] = s_r.done;
            readMux[sacs_pkg::STS_STROBE_ERR] = s_r.strobeErr;
        end
        else if (adr_i[7:5] == sacs_pkg::REG_RESULT[7:5] && adr_i[1:0] == 2'b00)
        begin
            readMux[15:0] = s_r.res[adr_i[4:2]];
        end
    end

    // Next state
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.doutMeta = link.dataFromDev;
        s_nxt.doutSync = s_r.doutMeta;
        s_nxt.strMeta = link.conversionStrobe;
        s_nxt.strSync = s_r.strMeta;
        s_nxt.halfCnt = tick ? 8'h00 : s_r.halfCnt + 8'h01;
        if (tick)
        begin
            s_nxt.sclk = !s_r.sclk;
        end
        // Bus: ack one cycle after request, write on the acked edge
        s_nxt.ack = wbReq & !s_r.ack;
        if (wbReq & !s_r.ack)
        begin
            s_nxt.rdat = readMux;
        end
        if (wbReq && s_r.ack && we_i && sel_i[0])
        begin
            if (adr_i == sacs_pkg::REG_STATUS && dat_i[sacs_pkg::STS_DONE])
            begin
                s_nxt.done = 1'b0;
            end
            else if (adr_i == sacs_pkg::REG_CONTROL && s_r.state == H_IDLE)
            begin
                s_nxt.lastCh = dat_i[sacs_pkg::CTL_LAST_LSB +: 3];
                s_nxt.settle = dat_i[sacs_pkg::CTL_SETTLE_LSB +: 2];
                if (dat_i[sacs_pkg::CTL_GO])
                begin
                    s_nxt.state = H_SHIFT;
                    s_nxt.bits = 8'h00;
                    s_nxt.done = 1'b0;
                    s_nxt.strobeErr = 1'b0;
                    s_nxt.scan = (dat_i[sacs_pkg::CTL_SETTLE_LSB +: 2]
                        == sacs_pkg::SETTLE_NONE);
                end
            end
        end
        case (s_r.state)
            H_SHIFT:
            begin
                if (fall && s_r.csN)
                begin
                    s_nxt.csN = 1'b0;
                    s_nxt.din = txBit;
                end
                else if (fall && s_r.bits == total)
                begin
                    s_nxt.csN = 1'b1;
                    s_nxt.din = 1'b0;
                    if (s_r.scan)
                    begin
                        s_nxt.state = H_IDLE;
                        s_nxt.done = 1'b1;
                    end
                    else
                    begin
                        s_nxt.state = H_WAIT;
                        s_nxt.waitCnt = (s_r.settle == sacs_pkg::SETTLE_INT)
                            ? 32'(SETTLE_CYCLES)
                            : 32'(IDLE_WAIT);
                    end
                end
                else if (fall)
                begin
                    s_nxt.din = txBit;
                end
                else if (rise && !s_r.csN)
                begin
                    s_nxt.bits = bitsInc;
                    s_nxt.rx = rxInc;
                    if (bitsInc[3:0] == 4'h9 && s_r.strSync)
                    begin
                        s_nxt.strobeErr = 1'b1;
                    end
                    if (s_r.scan && bitsInc > 8'(sacs_pkg::CTRL_BITS)
                        && bitsInc[3:0] == 4'h8)
                    begin
                        // Keep lead zero and code, drop the tail
                        s_nxt.res[3'(wordNum - 8'h01)] = {1'b0, rxInc[14:3],
                            {sacs_pkg::TRAIL_ZEROS{1'b0}}};
                    end
                end
            end
            H_WAIT:
            begin
                s_nxt.waitCnt = s_r.waitCnt - 32'h0000_0001;
                if (s_r.waitCnt <= 32'h0000_0001)
                begin
                    s_nxt.state = H_SHIFT;
                    s_nxt.scan = 1'b1;
                    s_nxt.bits = 8'h00;
                end
            end
            default:
            begin
                s_nxt.bits = 8'h00;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
            s_r.lastCh <= sacs_pkg::LAST_CH_RESET;
            s_r.csN <= 1'b1;
            s_r.strMeta <= 1'b1;
            s_r.strSync <= 1'b1;
        end
        else if (ce)
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign dat_o = s_r.rdat;
    assign ack_o = s_r.ack;
    assign link.sclk = s_r.sclk;
    assign link.chipSelectN = s_r.csN;
    assign link.dataToDev = s_r.din;
endmodule // sacs_host
`default_nettype wire

// >>> sacs_link_props.sv
`timescale 1ns/1ps
`default_nettype none
module sacs_link_chk
(
    // Link clock and device reset
    input wire logic sclk,
    input wire logic rst_n,
    // Link signals
    input wire logic chipSelectN,
    input wire logic dataToDev,
    input wire logic dataFromDev,
    input wire logic conversionStrobe
);
    logic [4:0] lowCnt;
    logic [3:0] pos;
    logic [1:0] riseOut;
    logic [1:0] riseIn;
    default clocking cb @(posedge sclk);
    endclocking
    default disable iff (!rst_n);
    // Readout length, bit position and rising-edge snapshots
    always_ff @(posedge sclk)
    begin
        if (!rst_n || conversionStrobe)
        begin
            lowCnt <= 5'h00;
            pos <= 4'h0;
        end
        else
        begin
            lowCnt <= (lowCnt == 5'h1F) ? lowCnt : lowCnt + 5'h01;
            pos <= pos + 4'h1;
        end
        riseOut <= {dataFromDev, conversionStrobe};
        riseIn <= {chipSelectN, dataToDev};
    end
    property p_desel_strobe;
        chipSelectN [*3] |-> conversionStrobe;
    endproperty
    a_desel_strobe: assert property (p_desel_strobe)
        else $error("strobe low while deselected");
    property p_desel_dout;
        chipSelectN [*3] |-> !dataFromDev;
    endproperty
    a_desel_dout: assert property (p_desel_dout)
        else $error("serial output busy while deselected");
    property p_sixteen;
        $rose(conversionStrobe) |-> lowCnt >= 5'h10 || $past(chipSelectN)
            || !$past(rst_n);
    endproperty
    a_sixteen: assert property (p_sixteen)
        else $error("readout ended before sixteen bits");
    property p_start_byte;
        $fell(conversionStrobe) |-> $past(dataToDev, 8) && $past(dataToDev, 1);
    endproperty
    a_start_byte: assert property (p_start_byte)
        else $error("strobe fell without a control byte");
    property p_zero_bits;
        !conversionStrobe && (pos == 4'h0 || pos >= 4'hD) |-> !dataFromDev;
    endproperty
    a_zero_bits: assert property (p_zero_bits)
        else $error("fill bit of result word not zero");
    property p_out_on_fall;
        @(negedge sclk) disable iff (!rst_n)
            {dataFromDev, conversionStrobe} == riseOut;
    endproperty
    a_out_on_fall: assert property (p_out_on_fall)
        else $error("device output moved while clock high");
    property p_sel_in_read;
        !conversionStrobe |-> !chipSelectN;
    endproperty
    a_sel_in_read: assert property (p_sel_in_read)
        else $error("deselected during readout");
    property p_in_on_fall;
        @(negedge sclk) disable iff (!rst_n) {chipSelectN, dataToDev} == riseIn;
    endproperty
    a_in_on_fall: assert property (p_in_on_fall)
        else $error("host input moved while clock high");
endmodule // sacs_link_chk
`default_nettype wire

// >>> sacs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sacs_tb_top;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    logic clock, rst_n, devRstN, cyc, stb, we, ack;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [11:0] sampleCode;
    logic convStart, unipolar, singleEnded, extClockMode, track, quickSeen;
    logic [2:0] channelSel;
    sacs_pkg::sacs_power_t powerState;
    int convCount, errors, nChecks;
    sacs_link link();
    // Both ends facing each other
    sacs_host #(.SETTLE_CYCLES(200)) sacs_host_inst (.clock(clock),
        .rst_n(rst_n), .ce(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .link(link));
    sacs_device sacs_device_inst (.link(link), .rst_n(devRstN), .ce(1'b1),
        .sampleCode(sampleCode), .convStart(convStart),
        .channelSel(channelSel), .unipolar(unipolar),
        .singleEnded(singleEnded), .powerState(powerState),
        .extClockMode(extClockMode));
    sacs_link_chk sacs_link_chk_inst (.sclk(link.sclk), .rst_n(devRstN),
        .chipSelectN(link.chipSelectN), .dataToDev(link.dataToDev),
        .dataFromDev(link.dataFromDev),
        .conversionStrobe(link.conversionStrobe));
    function automatic logic [11:0] codeOf(input int i);
        return 12'h801 + 12'(i * 32'h0000_01F3);
    endfunction
    function automatic logic [31:0] word(input logic [11:0] c);
        return {16'h0000, 1'b0, c, 3'b000};
    endfunction
    // System clock
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // New code presented after each conversion while track is set
    always @(posedge link.sclk)
        if (track && convStart === 1'b1)
        begin
            convCount <= convCount + 1;
            sampleCode <= codeOf(convCount + 1);
        end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One classic Wishbone cycle
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do
            @(posedge clock);
        while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Poll until done, then clear it
    task automatic waitDone();
        logic [31:0] q;
        int n;
        q = ZERO;
        n = 0;
        while (q[1] !== 1'b1 && n < 5000)
        begin
            wb(1'b0, 8'h04, ZERO, 4'hF, q);
            n++;
            if (powerState === sacs_pkg::PWR_QUICK)
                quickSeen = 1'b1;
        end
        chk({31'h0, q[1]}, 32'h0000_0001);
        wb(1'b1, 8'h04, 32'h0000_0002, 4'hF, q);
        wb(1'b0, 8'h04, ZERO, 4'hF, q);
        chk(q, ZERO);
    endtask
    task automatic t_idle();
        logic [31:0] q;
        chk({31'h0, link.chipSelectN}, 32'h0000_0001);
        wb(1'b0, 8'h20, ZERO, 4'hF, q);
        chk(q, ZERO);
        wb(1'b1, 8'h10, 32'hFFFF_FFFF, 4'hF, q);
        wb(1'b0, 8'h10, ZERO, 4'hF, q);
        chk(q, ZERO);
        wb(1'b1, 8'h00, 32'h0000_0001, 4'hE, q);
        wb(1'b0, 8'h04, ZERO, 4'hF, q);
        chk(q, ZERO);
    endtask
    // Reset both ends mid-run, link clock running for the device
    task automatic t_reset();
        logic [31:0] q;
        devRstN <= 1'b0;
        rst_n <= 1'b0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        repeat (42) @(posedge clock);
        devRstN <= 1'b1;
        repeat (20) @(posedge clock);
        chk({31'h0, link.chipSelectN}, 32'h0000_0001);
        chk(powerState, sacs_pkg::PWR_AWAKE);
        wb(1'b0, 8'h00, ZERO, 4'hF, q);
        chk(q, 32'h0000_000E);
        wb(1'b0, 8'h20, ZERO, 4'hF, q);
        chk(q, ZERO);
    endtask
    task automatic t_single();
        logic [31:0] q;
        int base;
        base = convCount;
        wb(1'b1, 8'h00, 32'h0000_0001, 4'hF, q);
        waitDone();
        wb(1'b0, 8'h20, ZERO, 4'hF, q);
        chk(q, word(codeOf(base)));
        chk(convCount - base, 1);
        chk({channelSel, unipolar, singleEnded, extClockMode}, 6'h07);
        chk(powerState, sacs_pkg::PWR_AWAKE);
    endtask
    task automatic t_scan();
        logic [31:0] q;
        int base;
        base = convCount;
        wb(1'b1, 8'h00, 32'h0000_000F, 4'hF, q);
        wb(1'b0, 8'h04, ZERO, 4'hF, q);
        chk(q, 32'h0000_0001);
        wb(1'b1, 8'h00, 32'h0000_0001, 4'hF, q);
        waitDone();
        for (int i = 0; i < 8; i++)
        begin
            wb(1'b0, 8'h20 + 8'(4 * i), ZERO, 4'hF, q);
            chk(q, word(codeOf(base + i)));
        end
        chk(convCount - base, 8);
        chk(channelSel, 3'h7);
    endtask
    task automatic t_settle(input logic [1:0] mode, input int minNs);
        logic [31:0] q;
        time t0;
        track = 1'b0;
        quickSeen = 1'b0;
        t0 = $time;
        wb(1'b1, 8'h00, {26'h0, mode, 4'h1}, 4'hF, q);
        waitDone();
        chk(($time - t0) > minNs, 1'b1);
        chk(quickSeen, mode[1]);
        wb(1'b0, 8'h20, ZERO, 4'hF, q);
        chk(q, word(sampleCode));
        chk(powerState, sacs_pkg::PWR_AWAKE);
        track = 1'b1;
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        {rst_n, devRstN, cyc, stb, we, quickSeen} = 6'h00;
        adr = 8'h00;
        sel = 4'hF;
        wdat = ZERO;
        {convCount, errors, nChecks} = '0;
        track = 1'b1;
        sampleCode = codeOf(0);
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        repeat (42) @(posedge clock);
        devRstN <= 1'b1;
        repeat (20) @(posedge clock);
        t_idle();
        t_single();
        t_scan();
        t_reset();
        t_settle(2'b01, 4800);
        t_settle(2'b10, 1600);
        t_single();
        give_verdict();
    end
    // Watchdog
    initial
    begin
        #400000;
        errors++;
        give_verdict();
    end
endmodule // sacs_tb_top
`default_nettype wire
